/* core/tsm_observe_mux.sv */
// How it works
// - routing off: code 000 low, 001 high, 010 receive envelope
// - routing off: 011 tx nrz, 100 manchester+subcarrier, 101 manchester
// - manchester selections pass only at 106 kBd type A
// - routing bit set with a nonzero probe code: pin carries probe, source select ignored
// - probe chosen by the probe select field of the digital register
// - F4h gives serial receive data, E4h gives the valid flag
// - D4h gives the collision flag of the current bit
// - C4h gives the serial bit clock
// - B5h gives synced read strobe, A5h synced write strobe
// - 96h gives the core clock level
// - 83h gives phase demod output, E2h its amplitude detect
// - 00h means no probe, pin follows the source select field
// - 5-bit analog field selects aux pin source, codes 0 to C
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
module tsm_observe_mux (
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link mode
  input wire logic rate106TypeA,
  // serial signal switch sources
  input wire logic envelope,
  input wire logic txNrz,
  input wire logic manchSubcarrier,
  input wire logic manchData,
  // digital probe sources
  input wire logic sData,
  input wire logic sValid,
  input wire logic sColl,
  input wire logic sClock,
  input wire logic rdSync,
  input wire logic wrSync,
  input wire logic coreClk,
  input wire logic phaseDemodOutput,
  input wire logic phaseAmplitudeDetect,
  // test pins
  output logic testObservePin,
  output logic [tsm_pkg::ANA_W-1:0] analogProbeSelect
);

  // register state
  logic [tsm_pkg::SRC_W-1:0] observeSourceSelect_ff;
  logic digitalProbeRouteEn_ff;
  logic [tsm_pkg::DIGI_W-1:0] digitalProbeSelect_ff;
  logic [tsm_pkg::ANA_W-1:0] analogProbeSelect_ff;
  logic testObservePin_ff;
  logic nxt_testObservePin;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pready_ff;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic wrEn;
  logic setupPhase;
  logic probeBit;
  logic probeKnown;
  logic probeOn;
  logic srcBit;
  logic [tsm_pkg::NPROBE-1:0] probeBus;

  // apb phases: answer is given in the first access cycle
  assign setupPhase = psel && !penable && !pready_ff;
  assign wrEn = psel && penable && pready_ff && pwrite;

  // probe candidates in vector order
  assign probeBus = {phaseAmplitudeDetect, phaseDemodOutput, coreClk,
                     wrSync, rdSync, sClock, sColl, sValid, sData};

  // probe selection
  tsm_probe_decode #(
    .NP(tsm_pkg::NPROBE)
  ) u_decode (
    .probeCode(digitalProbeSelect_ff),
    .probeBus(probeBus),
    .probeBit(probeBit),
    .probeKnown(probeKnown)
  );

  // probe path is active only with routing bit set and a code present
  assign probeOn = digitalProbeRouteEn_ff &&
                   (digitalProbeSelect_ff != tsm_pkg::PRB_NONE);

  // serial signal switch
  always_comb begin
    case (observeSourceSelect_ff)
      tsm_pkg::SRC_LOW: srcBit = 1'b0;
      tsm_pkg::SRC_HIGH: srcBit = 1'b1;
      tsm_pkg::SRC_ENV: srcBit = envelope;
      tsm_pkg::SRC_NRZ: srcBit = txNrz;
      tsm_pkg::SRC_MANCH_SUB: begin
        srcBit = manchSubcarrier && rate106TypeA;
      end
      tsm_pkg::SRC_MANCH: begin
        srcBit = manchData && rate106TypeA;
      end
      default: srcBit = 1'b0; // reserved codes
    endcase
  end

  // final pin choice
  always_comb begin
    if (probeOn) begin
      nxt_testObservePin = probeBit;
    end else begin
      nxt_testObservePin = srcBit;
    end
  end

  // observation pin flop
  always_ff @(posedge clk) begin
    if (reset) begin
      testObservePin_ff <= 1'b0;
    end else if (ce) begin
      testObservePin_ff <= nxt_testObservePin;
    end
  end

  // observe control register
  always_ff @(posedge clk) begin
    if (reset) begin
      observeSourceSelect_ff <= tsm_pkg::RST_SRC;
      digitalProbeRouteEn_ff <= tsm_pkg::RST_ROUTE;
    end else if (ce && wrEn && paddr == tsm_pkg::OFS_OBSERVE) begin
      observeSourceSelect_ff <=
        pwdata[tsm_pkg::SRC_LSB +: tsm_pkg::SRC_W];
      digitalProbeRouteEn_ff <= pwdata[tsm_pkg::ROUTE_BIT];
    end
  end

  // digital test select register
  always_ff @(posedge clk) begin
    if (reset) begin
      digitalProbeSelect_ff <= tsm_pkg::RST_DIGI;
    end else if (ce && wrEn && paddr == tsm_pkg::OFS_DIGITAL) begin
      digitalProbeSelect_ff <= pwdata[tsm_pkg::DIGI_W-1:0];
    end
  end

  // analog test select register, drives the aux mux select
  always_ff @(posedge clk) begin
    if (reset) begin
      analogProbeSelect_ff <= tsm_pkg::RST_ANA;
    end else if (ce && wrEn && paddr == tsm_pkg::OFS_ANALOG) begin
      analogProbeSelect_ff <= pwdata[tsm_pkg::ANA_W-1:0];
    end
  end

  // read mux and error decode
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    case (paddr)
      tsm_pkg::OFS_OBSERVE: begin
        nxt_prdata[tsm_pkg::SRC_LSB +: tsm_pkg::SRC_W] =
          observeSourceSelect_ff;
        nxt_prdata[tsm_pkg::ROUTE_BIT] = digitalProbeRouteEn_ff;
      end
      tsm_pkg::OFS_DIGITAL: begin
        nxt_prdata[tsm_pkg::DIGI_W-1:0] = digitalProbeSelect_ff;
      end
      tsm_pkg::OFS_ANALOG: begin
        nxt_prdata[tsm_pkg::ANA_W-1:0] = analogProbeSelect_ff;
      end
      tsm_pkg::OFS_STATUS: begin
        nxt_prdata[tsm_pkg::ST_PIN] = testObservePin_ff;
        nxt_prdata[tsm_pkg::ST_PROBE_ON] = probeOn;
        nxt_prdata[tsm_pkg::ST_MANCH_OK] = rate106TypeA;
        nxt_prdata[tsm_pkg::ST_CODE_OK] = probeKnown;
        nxt_prdata[tsm_pkg::ST_ANA_LSB +: tsm_pkg::ANA_W] =
          analogProbeSelect_ff;
      end
      default: begin
        nxt_pslverr = 1'b1; // unmapped address
      end
    endcase
  end

  // apb answer flops: ready for one cycle after each setup
  always_ff @(posedge clk) begin
    if (reset) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      pready_ff <= setupPhase;
      if (setupPhase) begin
        pslverr_ff <= nxt_pslverr;
        prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
      end else begin
        pslverr_ff <= 1'b0;
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  // outputs straight from flops
  assign testObservePin = testObservePin_ff;
  assign analogProbeSelect = analogProbeSelect_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // checks on the routing result, the analog select and the apb ready one cycle after their cause
  a_low_code: assert property (
    @(posedge clk) disable iff (reset)
    (ce && !probeOn && observeSourceSelect_ff == tsm_pkg::SRC_LOW)
    |=> !testObservePin)
    else $error("pin not low for code 000");

  a_high_code: assert property (
    @(posedge clk) disable iff (reset)
    (ce && !probeOn && observeSourceSelect_ff == tsm_pkg::SRC_HIGH)
    |=> testObservePin)
    else $error("pin not high for code 001");

  a_env_follow: assert property (
    @(posedge clk) disable iff (reset)
    (ce && !probeOn && observeSourceSelect_ff == tsm_pkg::SRC_ENV)
    |=> testObservePin == $past(envelope))
    else $error("pin does not follow envelope");

  a_nrz_follow: assert property (
    @(posedge clk) disable iff (reset)
    (ce && !probeOn && observeSourceSelect_ff == tsm_pkg::SRC_NRZ)
    |=> testObservePin == $past(txNrz))
    else $error("pin does not follow tx nrz");

  a_manch_gate: assert property (
    @(posedge clk) disable iff (reset)
    (ce && !probeOn && !rate106TypeA &&
     (observeSourceSelect_ff == tsm_pkg::SRC_MANCH ||
      observeSourceSelect_ff == tsm_pkg::SRC_MANCH_SUB))
    |=> !testObservePin)
    else $error("manchester routed outside 106 kBd type A");

  a_manch_pass: assert property (
    @(posedge clk) disable iff (reset)
    (ce && !probeOn && rate106TypeA &&
     observeSourceSelect_ff == tsm_pkg::SRC_MANCH)
    |=> testObservePin == $past(manchData))
    else $error("manchester data not routed");

  a_probe_sdata: assert property (
    @(posedge clk) disable iff (reset)
    (ce && digitalProbeRouteEn_ff &&
     digitalProbeSelect_ff == tsm_pkg::PRB_SDATA)
    |=> testObservePin == $past(sData))
    else $error("probe F4h does not give serial data");

  a_probe_coll: assert property (
    @(posedge clk) disable iff (reset)
    (ce && digitalProbeRouteEn_ff &&
     digitalProbeSelect_ff == tsm_pkg::PRB_SCOLL)
    |=> testObservePin == $past(sColl))
    else $error("probe D4h does not give collision flag");

  a_probe_strobe: assert property (
    @(posedge clk) disable iff (reset)
    (ce && digitalProbeRouteEn_ff &&
     digitalProbeSelect_ff == tsm_pkg::PRB_WRSYNC)
    |=> testObservePin == $past(wrSync))
    else $error("probe A5h does not give write strobe");

  a_probe_phase: assert property (
    @(posedge clk) disable iff (reset)
    (ce && digitalProbeRouteEn_ff &&
     digitalProbeSelect_ff == tsm_pkg::PRB_PHAMP)
    |=> testObservePin == $past(phaseAmplitudeDetect))
    else $error("probe E2h does not give amplitude detect");

  a_probe_valid: assert property (
    @(posedge clk) disable iff (reset)
    (ce && digitalProbeRouteEn_ff &&
     digitalProbeSelect_ff == tsm_pkg::PRB_SVALID)
    |=> testObservePin == $past(sValid))
    else $error("probe E4h does not give valid flag");

  a_probe_sclock: assert property (
    @(posedge clk) disable iff (reset)
    (ce && digitalProbeRouteEn_ff &&
     digitalProbeSelect_ff == tsm_pkg::PRB_SCLOCK)
    |=> testObservePin == $past(sClock))
    else $error("probe C4h does not give serial clock");

  a_probe_read: assert property (
    @(posedge clk) disable iff (reset)
    (ce && digitalProbeRouteEn_ff &&
     digitalProbeSelect_ff == tsm_pkg::PRB_RDSYNC)
    |=> testObservePin == $past(rdSync))
    else $error("probe B5h does not give read strobe");

  a_probe_coreclk: assert property (
    @(posedge clk) disable iff (reset)
    (ce && digitalProbeRouteEn_ff &&
     digitalProbeSelect_ff == tsm_pkg::PRB_CORECLK)
    |=> testObservePin == $past(coreClk))
    else $error("probe 96h does not give core clock");

  a_probe_demod: assert property (
    @(posedge clk) disable iff (reset)
    (ce && digitalProbeRouteEn_ff &&
     digitalProbeSelect_ff == tsm_pkg::PRB_PHDEMOD)
    |=> testObservePin == $past(phaseDemodOutput))
    else $error("probe 83h does not give demod output");

  a_none_follows: assert property (
    @(posedge clk) disable iff (reset)
    (ce && digitalProbeSelect_ff == tsm_pkg::PRB_NONE &&
     observeSourceSelect_ff == tsm_pkg::SRC_HIGH)
    |=> testObservePin)
    else $error("code 00h does not fall back to source select");

  a_rsv_low: assert property (
    @(posedge clk) disable iff (reset)
    (ce && !probeOn && observeSourceSelect_ff[2] &&
     observeSourceSelect_ff[1])
    |=> !testObservePin)
    else $error("reserved source code not low");

  a_ana_write: assert property (
    @(posedge clk) disable iff (reset)
    (ce && wrEn && paddr == tsm_pkg::OFS_ANALOG)
    |=> analogProbeSelect == $past(pwdata[tsm_pkg::ANA_W-1:0]))
    else $error("analog select not loaded");

  a_apb_ready: assert property (
    @(posedge clk) disable iff (reset)
    (ce && setupPhase) |=> pready ##1 (!pready || !ce))
    else $error("apb answer not one cycle");

  // main scenarios
  c_probe_route: cover property (
    @(posedge clk) disable iff (reset)
    probeOn && probeKnown && ce);
  c_manch_106: cover property (
    @(posedge clk) disable iff (reset)
    !probeOn && rate106TypeA &&
    observeSourceSelect_ff == tsm_pkg::SRC_MANCH_SUB);
  c_ana_max: cover property (
    @(posedge clk) disable iff (reset)
    analogProbeSelect_ff == tsm_pkg::ANA_MAX);
  c_bad_addr: cover property (
    @(posedge clk) disable iff (reset)
    pready && pslverr);

endmodule // tsm_observe_mux

/* core/tsm_pkg.sv */
package tsm_pkg;

  // register byte addresses on the apb slave
  localparam logic [7:0] OFS_OBSERVE = 8'h00;
  localparam logic [7:0] OFS_DIGITAL = 8'h04;
  localparam logic [7:0] OFS_ANALOG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // field layout of the observe control register
  localparam int SRC_LSB = 0;
  localparam int SRC_W = 3;
  localparam int ROUTE_BIT = 3;

  // widths of the probe and analog select fields
  localparam int DIGI_W = 8;
  localparam int ANA_W = 5;

  // status register bit positions
  localparam int ST_PIN = 0;
  localparam int ST_PROBE_ON = 1;
  localparam int ST_MANCH_OK = 2;
  localparam int ST_CODE_OK = 3;
  localparam int ST_ANA_LSB = 8;

  // reset values
  localparam logic [SRC_W-1:0] RST_SRC = 3'h0;
  localparam logic RST_ROUTE = 1'b0;
  localparam logic [DIGI_W-1:0] RST_DIGI = 8'h00;
  localparam logic [ANA_W-1:0] RST_ANA = 5'h00;

  // observation source codes
  localparam logic [SRC_W-1:0] SRC_LOW = 3'h0;
  localparam logic [SRC_W-1:0] SRC_HIGH = 3'h1;
  localparam logic [SRC_W-1:0] SRC_ENV = 3'h2;
  localparam logic [SRC_W-1:0] SRC_NRZ = 3'h3;
  localparam logic [SRC_W-1:0] SRC_MANCH_SUB = 3'h4;
  localparam logic [SRC_W-1:0] SRC_MANCH = 3'h5;

  // digital probe codes
  localparam logic [DIGI_W-1:0] PRB_NONE = 8'h00;
  localparam logic [DIGI_W-1:0] PRB_SDATA = 8'hF4;
  localparam logic [DIGI_W-1:0] PRB_SVALID = 8'hE4;
  localparam logic [DIGI_W-1:0] PRB_SCOLL = 8'hD4;
  localparam logic [DIGI_W-1:0] PRB_SCLOCK = 8'hC4;
  localparam logic [DIGI_W-1:0] PRB_RDSYNC = 8'hB5;
  localparam logic [DIGI_W-1:0] PRB_WRSYNC = 8'hA5;
  localparam logic [DIGI_W-1:0] PRB_CORECLK = 8'h96;
  localparam logic [DIGI_W-1:0] PRB_PHDEMOD = 8'h83;
  localparam logic [DIGI_W-1:0] PRB_PHAMP = 8'hE2;

  // probe vector layout
  localparam int NPROBE = 9;
  localparam logic [3:0] IDX_NONE = 4'hF;

  // highest defined analog select code
  localparam logic [ANA_W-1:0] ANA_MAX = 5'h0C;

  // maps a probe code onto its slot in the probe vector
  function automatic logic [3:0] probe_index(input logic [DIGI_W-1:0] c);
    case (c)
      PRB_SDATA: probe_index = 4'h0;
      PRB_SVALID: probe_index = 4'h1;
      PRB_SCOLL: probe_index = 4'h2;
      PRB_SCLOCK: probe_index = 4'h3;
      PRB_RDSYNC: probe_index = 4'h4;
      PRB_WRSYNC: probe_index = 4'h5;
      PRB_CORECLK: probe_index = 4'h6;
      PRB_PHDEMOD: probe_index = 4'h7;
      PRB_PHAMP: probe_index = 4'h8;
      default: probe_index = IDX_NONE;
    endcase
  endfunction

endpackage

/* core/tsm_probe_decode.sv */
`timescale 1ns/1ns
module tsm_probe_decode #(
  parameter int NP = tsm_pkg::NPROBE
) (
  // probe code and candidate signals
  input wire logic [tsm_pkg::DIGI_W-1:0] probeCode,
  input wire logic [NP-1:0] probeBus,
  // selected probe
  output logic probeBit,
  output logic probeKnown
);

  logic [3:0] idx;

  // pick the probe slot; unknown codes give a low level
  always_comb begin
    idx = tsm_pkg::probe_index(probeCode);
    probeKnown = (idx != tsm_pkg::IDX_NONE);
    probeBit = 1'b0;
    for (int i = 0; i < NP; i++) begin
      if (idx == i[3:0]) begin
        probeBit = probeBus[i];
      end
    end
  end

endmodule // tsm_probe_decode

/* testbench/tsm_lab_model.sv */
`timescale 1ns/1ns
module tsm_lab_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // level pattern asked for by the bench
  input wire logic [12:0] pattern,
  // source and probe levels fed into the block
  output logic [12:0] levels,
  // observation pin and what the probe saw
  input wire logic testObservePin,
  output logic seenPin
);
  logic [12:0] levels_ff;
  logic seen_ff;

  // stimulus generator: levels change only on the clock edge
  always_ff @(posedge clk) begin
    if (reset) begin
      levels_ff <= 13'h0000;
    end else begin
      levels_ff <= pattern;
    end
  end

  // scope probe: samples the observation pin once a cycle
  always_ff @(posedge clk) begin
    seen_ff <= testObservePin;
  end

  assign levels = levels_ff;
  assign seenPin = seen_ff;
endmodule // tsm_lab_model

/* testbench/tsm_observe_mux_tb.sv */
`timescale 1ns/1ns
module tsm_observe_mux_tb;
  // clock, reset and bus drive
  logic clk = 1'b0;
  logic reset;
  logic psel, penable, pwrite, rate106TypeA, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdData;
  logic rdErr, testObservePin, seenPin;
  logic [tsm_pkg::ANA_W-1:0] analogProbeSelect;
  logic [12:0] pattern, levels;
  int errors = 0;
  int cmp_count = 0;
  // analog select values written, both away from the reset value
  localparam logic [4:0] ANAV [2] = '{tsm_pkg::ANA_MAX, 5'h05};
  // per source code: level slot followed, or -1 for a fixed level
  localparam int SIDX [8] = '{-1, -1, 0, 1, 2, 3, -1, -1};
  localparam logic [7:0] SK = 8'h02;

  // 100 MHz clock
  always #5 clk = ~clk;

  tsm_observe_mux i_dut (
    .clk(clk), .reset(reset), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rate106TypeA(rate106TypeA),
    .envelope(levels[0]), .txNrz(levels[1]),
    .manchSubcarrier(levels[2]), .manchData(levels[3]),
    .sData(levels[4]), .sValid(levels[5]), .sColl(levels[6]),
    .sClock(levels[7]), .rdSync(levels[8]), .wrSync(levels[9]),
    .coreClk(levels[10]), .phaseDemodOutput(levels[11]),
    .phaseAmplitudeDetect(levels[12]),
    .testObservePin(testObservePin),
    .analogProbeSelect(analogProbeSelect)
  );

  tsm_lab_model i_lab (
    .clk(clk), .reset(reset), .pattern(pattern), .levels(levels),
    .testObservePin(testObservePin), .seenPin(seenPin)
  );

  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // compares one value
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic er);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      $display("[FAIL] pready expected 1 seen %b", pready);
      end_of_test();
    end else begin
      q = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdData, rdErr);
    chk("write_err", 32'h0, {31'h0, rdErr});
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    apb(1'b0, a, 32'h0, rdData, rdErr);
    chk(nm, e, rdData);
    chk("read_err", 32'h0, {31'h0, rdErr});
  endtask

  // selects a path, then drives the followed level low and high
  task automatic pinTest(input string nm, input logic [3:0] obs,
                         input logic [7:0] code, input logic rate,
                         input int idx, input logic k);
    logic [12:0] m;
    m = (idx >= 0) ? (13'h0001 << idx) : 13'h1FFF;
    wr(tsm_pkg::OFS_OBSERVE, {28'h0, obs});
    wr(tsm_pkg::OFS_DIGITAL, {24'h0, code});
    rate106TypeA <= rate;
    for (int v = 0; v < 2; v++) begin
      pattern <= (v == 1) ? m : ~m;
      repeat (4) @(posedge clk);
      chk(nm, (idx >= 0) ? 32'(v) : {31'h0, k}, {31'h0, seenPin});
    end
    $display("test %s done", nm);
  endtask

  // one source select code with probe code 00h
  task automatic srcTest(input int s);
    pinTest("source", {1'b0, 3'(s)}, 8'h00, 1'b1, SIDX[s], SK[s]);
  endtask

  // probe path with routing bit set over source code high
  task automatic probeTest(input string nm, input logic [7:0] code,
                           input int idx);
    pinTest(nm, 4'h9, code, 1'b1, idx, 1'b0);
  endtask

  // main sequence
  initial begin
    reset <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    rate106TypeA <= 1'b1;
    pattern <= 13'h0000;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rd("obs_rst", tsm_pkg::OFS_OBSERVE, 32'h0);
    rd("digi_rst", tsm_pkg::OFS_DIGITAL, 32'h0);
    rd("ana_rst", tsm_pkg::OFS_ANALOG, 32'h0);
    apb(1'b0, 8'h10, 32'h0, rdData, rdErr);
    chk("unmapped_err", 32'h1, {31'h0, rdErr});
    chk("unmapped_data", 32'h0, rdData);
    $display("test registers done");
    for (int s = 0; s < 3; s++) begin
      srcTest(s);
    end
    for (int s = 3; s < 6; s++) begin
      srcTest(s);
    end
    for (int s = 6; s < 8; s++) begin
      srcTest(s);
    end
    for (int s = 4; s < 6; s++) begin
      pinTest("manch_off", 4'(s), 8'h00, 1'b0, -1, 1'b0);
    end
    probeTest("p_sdata", tsm_pkg::PRB_SDATA, 4);
    probeTest("p_svalid", tsm_pkg::PRB_SVALID, 5);
    probeTest("p_scoll", tsm_pkg::PRB_SCOLL, 6);
    probeTest("p_sclock", tsm_pkg::PRB_SCLOCK, 7);
    probeTest("p_rdsync", tsm_pkg::PRB_RDSYNC, 8);
    probeTest("p_wrsync", tsm_pkg::PRB_WRSYNC, 9);
    probeTest("p_coreclk", tsm_pkg::PRB_CORECLK, 10);
    probeTest("p_phdemod", tsm_pkg::PRB_PHDEMOD, 11);
    probeTest("p_phamp", tsm_pkg::PRB_PHAMP, 12);
    pinTest("no_probe", 4'hA, tsm_pkg::PRB_NONE, 1'b1, 0, 1'b0);
    pinTest("route_off", 4'h3, tsm_pkg::PRB_SDATA, 1'b1, 1, 1'b0);
    for (int i = 0; i < 2; i++) begin
      wr(tsm_pkg::OFS_ANALOG, 32'(ANAV[i]));
      @(posedge clk);
      chk("analog_pin", 32'(ANAV[i]), 32'(analogProbeSelect));
      rd("analog_rd", tsm_pkg::OFS_ANALOG, 32'(ANAV[i]));
    end
    $display("test analog done");
    wr(tsm_pkg::OFS_DIGITAL, 32'h0);
    rd("digi_idle", tsm_pkg::OFS_DIGITAL, 32'h0);
    end_of_test();
  end
endmodule // tsm_observe_mux_tb
